/* File: core/byte_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module byte_fifo (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic ce,
    // Store side of the carrier
    fifo_if.store f
);
    logic [7:0] mem_q [ictl_pkg::DEPTH];
    logic [2:0] wptr_q, wptr_d, rptr_q, rptr_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] rdata_q;
    logic push_ok, pop_ok;

    // Pointer and count update; flush wins over everything
    always_comb begin
        push_ok = f.push && (cnt_q != ictl_pkg::FIFO_FULL_CNT);
        pop_ok = f.pop && (cnt_q != 4'h0);
        wptr_d = wptr_q;
        rptr_d = rptr_q;
        cnt_d = cnt_q;
        if (f.flush) begin
            wptr_d = 3'h0;
            rptr_d = 3'h0;
            cnt_d = 4'h0;
        end else begin
            if (push_ok) begin
                wptr_d = wptr_q + 3'h1;
            end
            if (pop_ok) begin
                rptr_d = rptr_q + 3'h1;
            end
            cnt_d = cnt_q + {3'h0, push_ok} - {3'h0, pop_ok};
        end
    end

    // Registers
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            wptr_q <= 3'h0;
            rptr_q <= 3'h0;
            cnt_q <= 4'h0;
            rdata_q <= 8'h00;
        end else if (ce) begin
            wptr_q <= wptr_d;
            rptr_q <= rptr_d;
            cnt_q <= cnt_d;
            rdata_q <= mem_q[rptr_q];
        end
    end

    // Storage has no reset, so it maps to plain RAM
    always_ff @(posedge clock) begin
        if (ce && push_ok && !f.flush) begin
            mem_q[wptr_q] <= f.wdata;
        end
    end

    assign f.rdata = rdata_q;
    assign f.count = cnt_q;
endmodule
`default_nettype wire

/* File: core/fifo_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Byte FIFO carrier between the controller and its stores
interface fifo_if;
    logic push;
    logic [7:0] wdata;
    logic pop;
    logic flush;
    logic [7:0] rdata;
    logic [3:0] count;
    modport owner(output push, output wdata, output pop, output flush, input rdata, input count);
    modport store(input push, input wdata, input pop, input flush, output rdata, output count);
endinterface
`default_nettype wire

/* File: core/i2c_enable_abort_control.sv */
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Abort field reads one while an abort runs, zero otherwise.
// - Enable bit zero means disabled with both FIFOs held erased; one enables.
// - Disabling flushes every entry of transmit and receive FIFOs.
// - After disable, interrupt status stays live until the engine is idle.
// - Disabled mid-transmit: finish current byte, then stop with transmit data dropped.
// - Disabled mid-receive: reception stops at once.
// - A disable write is accepted even while a transfer runs.
// - With asynchronous clocks, enable changes take effect two core cycles late.
// - Abort set only while enabled; writes otherwise ignored; software cannot clear it.
// - Abort: finish byte, stop, flush transmit, raise abort interrupt, self-clear.
module i2c_enable_abort_control #(
    parameter bit CLK_ASYNC = 1'b1
) (
    // Core clock, reset, freeze
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Interrupt
    output logic irq,
    // Link pins
    input wire logic link_clk,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n
);
    // ---------------------------------------------
    // Declarations
    // ---------------------------------------------
    fifo_if tx_f();
    fifo_if rx_f();
    logic en_req_q, en_req_d, rx_dir_q, rx_dir_d, abort_q, abort_d;
    logic [1:0] en_pipe_q, en_pipe_d;
    logic [2:0] mask_q, mask_d, intr_q, intr_d, set_ev;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d, pslverr_q, pslverr_d, irq_q, irq_d;
    ictl_pkg::eng_state_e state_q, state_d;
    logic [7:0] shift_q, shift_d;
    logic [3:0] bit_cnt_q, bit_cnt_d;
    logic cur_rx_q, cur_rx_d, sda_o_q, sda_o_d, oe_n_q, oe_n_d;
    logic link_lvl, sda_lvl, link_prev_q, link_rise;
    logic en_eff, setup, acc_done, wr_done, rd_done, abort_done;
    logic [2:0] w1c;

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a == ictl_pkg::ADDR_CTRL) || (a == ictl_pkg::ADDR_STATUS) ||
                  (a == ictl_pkg::ADDR_INTR_STAT) || (a == ictl_pkg::ADDR_INTR_MASK) ||
                  (a == ictl_pkg::ADDR_TX_DATA) || (a == ictl_pkg::ADDR_RX_DATA);
    endfunction

    // ---------------------------------------------
    // Link pin sampling and FIFOs
    // ---------------------------------------------
    link_sync u_clk_sync (.clock(clock), .sys_rst(sys_rst), .ce(ce), .din(link_clk), .dout(link_lvl));
    link_sync u_sda_sync (.clock(clock), .sys_rst(sys_rst), .ce(ce), .din(sda_i), .dout(sda_lvl));
    byte_fifo u_tx_fifo (.clock(clock), .sys_rst(sys_rst), .ce(ce), .f(tx_f));
    byte_fifo u_rx_fifo (.clock(clock), .sys_rst(sys_rst), .ce(ce), .f(rx_f));

    assign link_rise = link_lvl && !link_prev_q;

    // ---------------------------------------------
    // Enable path and bus strobes
    // ---------------------------------------------
    // Two core cycles from control bit to effect when clocks are unrelated
    assign en_eff = CLK_ASYNC ? en_pipe_q[1] : en_req_q;
    assign setup = psel && !penable;
    assign acc_done = psel && penable && pready_q;
    assign wr_done = acc_done && pwrite;
    assign rd_done = acc_done && !pwrite;
    assign w1c = (wr_done && paddr == ictl_pkg::ADDR_INTR_STAT) ? pwdata[2:0] : 3'h0;

    // FIFO requests; disabled state holds both stores erased
    always_comb begin
        tx_f.push = wr_done && (paddr == ictl_pkg::ADDR_TX_DATA) && en_eff;
        tx_f.wdata = pwdata[7:0];
        tx_f.flush = !en_eff || abort_done;
        rx_f.flush = !en_eff;
        rx_f.pop = rd_done && (paddr == ictl_pkg::ADDR_RX_DATA);
        rx_f.wdata = {shift_q[6:0], sda_lvl};
    end

    // ---------------------------------------------
    // Transfer engine
    // ---------------------------------------------
    // One byte per eight link clock rises; stop drives the line low for one bit
    always_comb begin
        state_d = state_q;
        shift_d = shift_q;
        bit_cnt_d = bit_cnt_q;
        cur_rx_d = cur_rx_q;
        sda_o_d = sda_o_q;
        oe_n_d = oe_n_q;
        tx_f.pop = 1'b0;
        rx_f.push = 1'b0;
        set_ev = 3'h0;
        abort_done = 1'b0;
        case (state_q)
            ictl_pkg::ST_IDLE: begin
                oe_n_d = 1'b1;
                if (abort_q) begin
                    state_d = ictl_pkg::ST_STOP;
                end else if (en_eff && rx_dir_q) begin
                    cur_rx_d = 1'b1;
                    bit_cnt_d = ictl_pkg::BITS_PER_BYTE;
                    state_d = ictl_pkg::ST_SHIFT;
                end else if (en_eff && tx_f.count != 4'h0) begin
                    cur_rx_d = 1'b0;
                    state_d = ictl_pkg::ST_LOAD;
                end
            end
            ictl_pkg::ST_LOAD: begin
                // Read word settled one cycle ago, so it is safe to take here
                shift_d = tx_f.rdata;
                tx_f.pop = 1'b1;
                bit_cnt_d = ictl_pkg::BITS_PER_BYTE;
                sda_o_d = tx_f.rdata[7];
                oe_n_d = 1'b0;
                state_d = ictl_pkg::ST_SHIFT;
            end
            ictl_pkg::ST_SHIFT: begin
                if (cur_rx_q && !en_eff) begin
                    state_d = ictl_pkg::ST_IDLE;
                    oe_n_d = 1'b1;
                end else if (link_rise) begin
                    // Transmit keeps going with enable low: the byte finishes
                    bit_cnt_d = bit_cnt_q - 4'h1;
                    shift_d = {shift_q[6:0], cur_rx_q ? sda_lvl : 1'b0};
                    sda_o_d = shift_q[6];
                    if (bit_cnt_q == 4'h1) begin
                        oe_n_d = 1'b1;
                        if (cur_rx_q) begin
                            rx_f.push = 1'b1;
                            set_ev[ictl_pkg::INTR_RX_DONE] = 1'b1;
                        end else begin
                            set_ev[ictl_pkg::INTR_TX_DONE] = 1'b1;
                        end
                        state_d = abort_q ? ictl_pkg::ST_STOP : ictl_pkg::ST_IDLE;
                    end
                end
            end
            ictl_pkg::ST_STOP: begin
                sda_o_d = 1'b0;
                oe_n_d = 1'b0;
                if (link_rise) begin
                    oe_n_d = 1'b1;
                    abort_done = 1'b1;
                    set_ev[ictl_pkg::INTR_TX_ABORT] = 1'b1;
                    state_d = ictl_pkg::ST_IDLE;
                end
            end
            default: begin
                state_d = ictl_pkg::ST_IDLE;
            end
        endcase
    end

    // ---------------------------------------------
    // Register file
    // ---------------------------------------------
    // Control, interrupt and bus answer next values
    always_comb begin
        en_req_d = en_req_q;
        rx_dir_d = rx_dir_q;
        mask_d = mask_q;
        en_pipe_d = {en_pipe_q[0], en_req_q};
        if (wr_done && paddr == ictl_pkg::ADDR_CTRL) begin
            en_req_d = pwdata[ictl_pkg::CTRL_ENABLE_BIT];
            rx_dir_d = pwdata[ictl_pkg::CTRL_RX_DIR_BIT];
        end
        if (wr_done && paddr == ictl_pkg::ADDR_INTR_MASK) begin
            mask_d = pwdata[2:0];
        end
        // Set only while enabled, never cleared by software
        // A new request beats the self-clear of the one that just ended
        abort_d = abort_q;
        if (abort_done) begin
            abort_d = 1'b0;
        end
        if (wr_done && paddr == ictl_pkg::ADDR_CTRL && pwdata[ictl_pkg::CTRL_ABORT_BIT] && en_req_q) begin
            abort_d = 1'b1;
        end
        // Sticky bits; a new event beats the clear in the same cycle
        intr_d = intr_q & ~w1c;
        if (!en_eff && state_q == ictl_pkg::ST_IDLE) begin
            intr_d = 3'h0;
        end
        intr_d = intr_d | set_ev;
        irq_d = |(intr_q & mask_q);
        // Zero-wait slave: answer is ready in the first access cycle
        pready_d = setup;
        pslverr_d = setup && !addr_ok(paddr);
        prdata_d = prdata_q;
        if (setup && !pwrite) begin
            case (paddr)
                ictl_pkg::ADDR_CTRL: prdata_d = {29'h0, rx_dir_q, abort_q, en_req_q};
                ictl_pkg::ADDR_STATUS: prdata_d = {20'h0, rx_f.count, tx_f.count, 1'b0, en_eff, abort_q,
                                                   state_q != ictl_pkg::ST_IDLE};
                ictl_pkg::ADDR_INTR_STAT: prdata_d = {29'h0, intr_q};
                ictl_pkg::ADDR_INTR_MASK: prdata_d = {29'h0, mask_q};
                ictl_pkg::ADDR_RX_DATA: prdata_d = {24'h0, rx_f.rdata};
                default: prdata_d = 32'h0000_0000;
            endcase
        end
    end

    // All state, frozen while ce is low
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            en_req_q <= 1'b0;
            rx_dir_q <= 1'b0;
            abort_q <= 1'b0;
            en_pipe_q <= 2'h0;
            mask_q <= ictl_pkg::MASK_RESET;
            intr_q <= ictl_pkg::INTR_RESET;
            irq_q <= 1'b0;
            prdata_q <= ictl_pkg::PRDATA_RESET;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            state_q <= ictl_pkg::ST_IDLE;
            shift_q <= 8'h00;
            bit_cnt_q <= 4'h0;
            cur_rx_q <= 1'b0;
            sda_o_q <= 1'b1;
            oe_n_q <= 1'b1;
            link_prev_q <= 1'b0;
        end else if (ce) begin
            en_req_q <= en_req_d;
            rx_dir_q <= rx_dir_d;
            abort_q <= abort_d;
            en_pipe_q <= en_pipe_d;
            mask_q <= mask_d;
            intr_q <= intr_d;
            irq_q <= irq_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            state_q <= state_d;
            shift_q <= shift_d;
            bit_cnt_q <= bit_cnt_d;
            cur_rx_q <= cur_rx_d;
            sda_o_q <= sda_o_d;
            oe_n_q <= oe_n_d;
            link_prev_q <= link_lvl;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq = irq_q;
    assign sda_o = sda_o_q;
    assign sda_oe_n = oe_n_q;

    // ---------------------------------------------
    // Checks
    // ---------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    sequence seq_stop_end;
        state_q == ictl_pkg::ST_STOP && link_rise && !wr_done;
    endsequence
    sequence seq_abort_clean;
        state_q == ictl_pkg::ST_IDLE && !abort_q && intr_q[ictl_pkg::INTR_TX_ABORT] && tx_f.count == 4'h0;
    endsequence

    AST_ABORT_FALL: assert property ($fell(abort_q) |-> $past(state_q) == ictl_pkg::ST_STOP)
        else $error("abort bit fell outside stop");
    AST_HELD_ERASED: assert property (!en_eff [*2] |-> tx_f.count == 4'h0 && rx_f.count == 4'h0)
        else $error("fifo not erased while disabled");
    AST_FLUSH: assert property ($fell(en_eff) |=> tx_f.count == 4'h0 ##0 rx_f.count == 4'h0)
        else $error("fifo not flushed on disable");
    AST_INTR_LIVE: assert property (!en_eff && state_q != ictl_pkg::ST_IDLE && w1c == 3'h0 |=>
        (intr_q & $past(intr_q)) == $past(intr_q)) else $error("interrupt status dropped before idle");
    AST_INTR_CLEAR: assert property (!en_eff && state_q == ictl_pkg::ST_IDLE |=> intr_q == 3'h0)
        else $error("interrupt status kept after idle");
    AST_TX_FINISH: assert property (state_q == ictl_pkg::ST_SHIFT && !cur_rx_q && !link_rise
        |=> state_q == ictl_pkg::ST_SHIFT) else $error("transmit byte cut short");
    AST_RX_STOP: assert property (state_q == ictl_pkg::ST_SHIFT && cur_rx_q && !en_eff
        |=> state_q == ictl_pkg::ST_IDLE) else $error("receive did not stop");
    AST_DIS_ACCEPT: assert property (wr_done && paddr == ictl_pkg::ADDR_CTRL && !pwdata[0] |=> !en_req_q)
        else $error("disable write ignored");
    AST_EN_DELAY: assert property (CLK_ASYNC |-> ##2 en_eff == $past(en_req_q, 2))
        else $error("enable delay wrong");
    AST_ABORT_GATE: assert property ($rose(abort_q) |-> $past(en_req_q) && $past(wr_done))
        else $error("abort set while disabled");
    AST_ABORT_SEQ: assert property (seq_stop_end |=> seq_abort_clean)
        else $error("abort ending incomplete");
endmodule
`default_nettype wire

/* File: core/ictl_pkg.sv */
package ictl_pkg;
    // ---------------------------------------------
    // Widths and depths
    // ---------------------------------------------
    localparam int unsigned DATA_W = 8;
    localparam int unsigned DEPTH = 8;
    localparam int unsigned PTR_W = 3;
    localparam int unsigned CNT_W = 4;
    localparam logic [3:0] FIFO_FULL_CNT = 4'h8;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam int unsigned EN_DELAY_CYCLES = 2;

    // ---------------------------------------------
    // Register byte addresses
    // ---------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_INTR_STAT = 8'h08;
    localparam logic [7:0] ADDR_INTR_MASK = 8'h0c;
    localparam logic [7:0] ADDR_TX_DATA = 8'h10;
    localparam logic [7:0] ADDR_RX_DATA = 8'h14;

    // ---------------------------------------------
    // Field positions and reset values
    // ---------------------------------------------
    localparam int unsigned CTRL_ENABLE_BIT = 0;
    localparam int unsigned CTRL_ABORT_BIT = 1;
    localparam int unsigned CTRL_RX_DIR_BIT = 2;
    localparam int unsigned ST_ACTIVITY_BIT = 0;
    localparam int unsigned ST_ABORT_BIT = 1;
    localparam int unsigned ST_EN_BIT = 2;
    localparam int unsigned ST_TXCNT_LSB = 4;
    localparam int unsigned ST_RXCNT_LSB = 8;
    localparam int unsigned INTR_W = 3;
    localparam int unsigned INTR_TX_ABORT = 0;
    localparam int unsigned INTR_RX_DONE = 1;
    localparam int unsigned INTR_TX_DONE = 2;
    localparam logic [2:0] INTR_RESET = 3'h0;
    localparam logic [2:0] MASK_RESET = 3'h0;
    localparam logic [31:0] PRDATA_RESET = 32'h0000_0000;

    // ---------------------------------------------
    // Transfer engine states, Gray along the path
    // ---------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOAD = 2'b01,
        ST_SHIFT = 2'b11,
        ST_STOP = 2'b10
    } eng_state_e;
endpackage

/* File: core/link_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module link_sync (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic ce,
    // Pin in, settled level out
    input wire logic din,
    output logic dout
);
    logic s1_q, s2_q, s3_q, lvl_q;
    logic lvl_d;

    // Level moves only once stages two and three agree
    always_comb begin
        lvl_d = lvl_q;
        if (s2_q == s3_q) begin
            lvl_d = s3_q;
        end
    end

    // Three-stage sampler
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            lvl_q <= 1'b0;
        end else if (ce) begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            lvl_q <= lvl_d;
        end
    end

    assign dout = lvl_q;
endmodule
`default_nettype wire

/* File: test/link_partner.sv */
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------
// Bus device on the far side of the link
// ---------------------------------------------
module link_partner (
    // Device pins
    input wire logic sda_o,
    input wire logic sda_oe_n,
    output logic link_clk,
    output logic sda_i,
    // Bits seen at each link rise
    output logic [7:0] cap
);
    logic drv = 1'b1;
    logic [7:0] rx_b = 8'h00;
    int idx = 0;
    initial link_clk = 1'b0;
    initial cap = 8'h00;
    // Wired-and line; the pull-up wins once both sides let go
    assign sda_i = (sda_oe_n ? 1'b1 : sda_o) & drv;
    // Shift in whatever the line holds at the rise
    always @(posedge link_clk) begin
        cap <= {cap[6:0], sda_i};
    end
    // Load a byte for the device to receive
    task automatic send(input logic [7:0] b);
        rx_b = b;
        idx = 0;
    endtask
    // Clock stands still outside frames, so it only runs here
    task automatic bits(input int n, input logic rx);
        // Pin changes land on core clock edges, so they go in late to avoid a race
        for (int i = 0; i < n; i++) begin
            drv <= rx ? rx_b[3'(7 - idx)] : 1'b1; // MSB first
            #400 link_clk <= 1'b1;
            #400 link_clk <= 1'b0;
            idx++;
        end
        drv <= 1'b1;
    endtask
endmodule
`default_nettype wire

/* File: test/tb_i2c_enable_abort_control.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_i2c_enable_abort_control;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, irq, link_clk, sda_i, sda_o, sda_oe_n;
    logic [7:0] cap, b0, b1, b2;
    logic [31:0] rdv;
    logic last_err;
    logic [15:0] lfsr_q = 16'h29b4;
    int err_total = 0;
    int cmp_count = 0;

    // ---------------------------------------------
    // Design, far-side device, clock
    // ---------------------------------------------
    i2c_enable_abort_control u_dut (.clock(clock), .sys_rst(sys_rst), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .link_clk(link_clk), .sda_i(sda_i),
        .sda_o(sda_o), .sda_oe_n(sda_oe_n));
    link_partner u_part (.sda_o(sda_o), .sda_oe_n(sda_oe_n), .link_clk(link_clk), .sda_i(sda_i),
        .cap(cap));
    always #50 clock = ~clock;

    // ---------------------------------------------
    // Helpers
    // ---------------------------------------------
    // Status left after a one-to-clear write
    function automatic logic [2:0] w1c(input logic [2:0] s, input logic [2:0] w);
        return s & ~w;
    endfunction
    // Next state of the fixed-seed random source
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Fixed-seed random byte
    task automatic draw(output logic [7:0] b);
        lfsr_q = lfsr_next(lfsr_q);
        b = lfsr_q[7:0];
    endtask
    // APB transfer; request held until pready seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        // No wait count assumed; only the hang guard ends this
        @(posedge clock);
        while (pready !== 1'b1) begin
            @(posedge clock);
        end
        rdv = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic st();
        rd(ictl_pkg::ADDR_STATUS);
    endtask
    // Bounded wait for the engine to go idle
    task automatic poll_idle();
        int n;
        n = 0;
        st();
        while (rdv[ictl_pkg::ST_ACTIVITY_BIT] !== 1'b0 && n < 40) begin
            st();
            n++;
        end
        if (n >= 40) begin
            err_total++;
            summarize();
        end
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // ---------------------------------------------
    // Scenarios
    // ---------------------------------------------
    initial begin
        repeat (3) @(posedge clock);
        sys_rst <= 1'b0;
        // Reset state and an unmapped word
        rd(ictl_pkg::ADDR_CTRL);
        `CHK("ctrl", 32'h0, rdv)
        rd(8'h18);
        `CHK("slverr", 1'b1, last_err)
        `CHK("unmapped", 32'h0, rdv)
        // Abort and data ignored while disabled
        wr(ictl_pkg::ADDR_CTRL, 32'h2);
        wr(ictl_pkg::ADDR_TX_DATA, 32'h55);
        st();
        `CHK("abort off", 1'b0, rdv[ictl_pkg::ST_ABORT_BIT])
        `CHK("tx held", 4'h0, rdv[ictl_pkg::ST_TXCNT_LSB +: 4])
        wr(ictl_pkg::ADDR_CTRL, 32'h1);
        repeat (2) @(posedge clock);
        st();
        `CHK("enabled", 1'b1, rdv[ictl_pkg::ST_EN_BIT])
        // One random byte out, then interrupt mask and clear
        draw(b0);
        wr(ictl_pkg::ADDR_TX_DATA, {24'h0, b0});
        u_part.bits(8, 1'b0);
        `CHK("tx byte", b0, cap)
        poll_idle();
        rd(ictl_pkg::ADDR_INTR_STAT);
        `CHK("tx done", 1'b1, rdv[ictl_pkg::INTR_TX_DONE])
        `CHK("irq masked", 1'b0, irq)
        wr(ictl_pkg::ADDR_INTR_MASK, 32'h4);
        repeat (2) @(posedge clock);
        `CHK("irq on", 1'b1, irq)
        wr(ictl_pkg::ADDR_INTR_STAT, 32'h4);
        repeat (2) @(posedge clock);
        `CHK("irq off", 1'b0, irq)
        rd(ictl_pkg::ADDR_INTR_STAT);
        `CHK("w1c", w1c(3'h4, 3'h4), rdv[2:0])
        // Abort in mid-byte with a second byte queued
        draw(b1);
        draw(b2);
        wr(ictl_pkg::ADDR_TX_DATA, {24'h0, b1});
        wr(ictl_pkg::ADDR_TX_DATA, {24'h0, b2});
        u_part.bits(3, 1'b0);
        wr(ictl_pkg::ADDR_CTRL, 32'h3);
        st();
        `CHK("abort run", 1'b1, rdv[ictl_pkg::ST_ABORT_BIT])
        wr(ictl_pkg::ADDR_CTRL, 32'h1);
        st();
        `CHK("abort kept", 1'b1, rdv[ictl_pkg::ST_ABORT_BIT])
        u_part.bits(5, 1'b0);
        `CHK("abort byte", b1, cap)
        u_part.bits(1, 1'b0);
        poll_idle();
        `CHK("abort done", 1'b0, rdv[ictl_pkg::ST_ABORT_BIT])
        `CHK("abort flush", 4'h0, rdv[ictl_pkg::ST_TXCNT_LSB +: 4])
        rd(ictl_pkg::ADDR_INTR_STAT);
        `CHK("abort intr", 1'b1, rdv[ictl_pkg::INTR_TX_ABORT])
        wr(ictl_pkg::ADDR_INTR_STAT, 32'h7);
        // Disable during the second of three bytes
        wr(ictl_pkg::ADDR_TX_DATA, {24'h0, b0});
        wr(ictl_pkg::ADDR_TX_DATA, {24'h0, b1});
        wr(ictl_pkg::ADDR_TX_DATA, {24'h0, b2});
        u_part.bits(8, 1'b0);
        `CHK("first", b0, cap)
        u_part.bits(3, 1'b0);
        wr(ictl_pkg::ADDR_CTRL, 32'h0);
        rd(ictl_pkg::ADDR_INTR_STAT);
        `CHK("intr live", 1'b1, rdv[ictl_pkg::INTR_TX_DONE])
        `CHK("irq live", 1'b1, irq)
        u_part.bits(5, 1'b0);
        `CHK("finished", b1, cap)
        poll_idle();
        `CHK("tx flushed", 4'h0, rdv[ictl_pkg::ST_TXCNT_LSB +: 4])
        `CHK("disabled", 1'b0, rdv[ictl_pkg::ST_EN_BIT])
        rd(ictl_pkg::ADDR_INTR_STAT);
        `CHK("intr idle", 3'h0, rdv[2:0])
        u_part.bits(8, 1'b0);
        `CHK("no drive", 1'b1, sda_oe_n)
        // Receive one byte, then disable in mid-byte
        wr(ictl_pkg::ADDR_CTRL, 32'h5);
        u_part.send(b2);
        u_part.bits(8, 1'b1);
        repeat (6) @(posedge clock);
        st();
        `CHK("rx count", 4'h1, rdv[ictl_pkg::ST_RXCNT_LSB +: 4])
        rd(ictl_pkg::ADDR_RX_DATA);
        `CHK("rx byte", b2, rdv[7:0])
        rd(ictl_pkg::ADDR_INTR_STAT);
        `CHK("rx done", 1'b1, rdv[ictl_pkg::INTR_RX_DONE])
        u_part.send(b1);
        u_part.bits(3, 1'b1);
        wr(ictl_pkg::ADDR_CTRL, 32'h4);
        // Second status read falls after the two-cycle enable delay
        st();
        st();
        `CHK("rx halt", 1'b0, rdv[ictl_pkg::ST_ACTIVITY_BIT])
        u_part.bits(5, 1'b1);
        repeat (6) @(posedge clock);
        poll_idle();
        `CHK("rx stopped", 4'h0, rdv[ictl_pkg::ST_RXCNT_LSB +: 4])
        summarize();
    end

    // Hang guard, well beyond the expected run
    initial begin
        #2000000;
        err_total++;
        summarize();
    end
endmodule
`default_nettype wire
